// [design/swc_sleep_ctrl.sv]
// sleep entry, wake-up, watchdog clear and regulator mode control
// ==========================================================
// Functional notes
// [R1] with interrupts globally off, any enabled flagged source but clock-switch wakes
// [R2] source already pending at sleep instruction: instruction becomes a no-op
// [R3] on a no-op the watchdog counter and prescaler keep their values
// [R4] on a no-op time-out flag not set, power-down flag not cleared
// [R5] source arriving during or after the instruction: complete, then wake at once
// [R6] completed sleep clears watchdog counter and prescaler
// [R7] completed sleep sets time-out flag and clears power-down flag
// [R8] firmware reads power-down flag set as meaning the instruction was a no-op
// [R9] regulator and reference stay enabled throughout sleep in both modes
// [R10] power-mode bit set puts regulator and reference into low power while asleep
// [R11] default mode keeps regulator normal, so wake needs no extra delay
// [R12] waking from low-power sleep inserts a stabilisation delay before resuming
// [R13] wake with interrupts globally off resumes at next instruction, no vector
`timescale 1ns/100ps
module swc_sleep_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	// core side
	input wire logic sleep_instr,
	input wire logic global_irq_enable,
	input wire logic [swc_pkg::NUM_SRC-1:0] irq_enable,
	input wire logic [swc_pkg::NUM_SRC-1:0] irq_flag,
	input wire logic wdt_timeout,
	output logic core_stall,
	output logic sleeping,
	output logic resume,
	output logic resume_vector,
	output logic sleep_nop,
	// watchdog
	output logic wdt_clear,
	output logic wdt_prescaler_clear,
	// regulator
	output logic regulator_enable,
	output logic regulator_low_power,
	// status flags
	output logic timeout_flag_n,
	output logic powerdown_flag_n,
	// register port
	input wire logic [swc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [swc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [swc_pkg::DATA_W-1:0] reg_rdata,
	output logic irq
);

	// ==========================================================
	// wake qualification
	logic pending;

	swc_wake_qual #(
		.N(swc_pkg::NUM_SRC),
		.EXCL(swc_pkg::CLKSW_SRC)
	) u_qual (
		.irq_enable(irq_enable),
		.irq_flag(irq_flag),
		.pending(pending)
	); // R1

	// ==========================================================
	// registers written by software
	logic [swc_pkg::DATA_W-1:0] control;
	logic [swc_pkg::NUM_EV-1:0] ev_mask;
	logic regulator_power_mode;

	assign regulator_power_mode = control[swc_pkg::CTRL_PM_BIT];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			control <= swc_pkg::CONTROL_RST;
		end else if (reg_write && reg_addr == swc_pkg::REG_CONTROL) begin
			control <= {7'h00, reg_wdata[swc_pkg::CTRL_PM_BIT]}; // R10
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ev_mask <= swc_pkg::MASK_RST;
		end else if (reg_write && reg_addr == swc_pkg::REG_MASK) begin
			ev_mask <= reg_wdata[swc_pkg::NUM_EV-1:0];
		end
	end

	// ==========================================================
	// sleep sequencer
	swc_pkg::swc_state_t state;
	swc_pkg::swc_state_t next_state;
	logic [swc_pkg::CNT_W-1:0] cnt;
	logic [swc_pkg::CNT_W-1:0] next_cnt;
	logic wake_seen;
	logic lp_sleep;
	logic take_nop;
	logic complete;
	logic wake_now;

	localparam logic [swc_pkg::CNT_W-1:0] EXEC_LAST =
		swc_pkg::CNT_W'(swc_pkg::SLEEP_EXEC_CYCLES - 1);
	localparam logic [swc_pkg::CNT_W-1:0] STAB_LAST =
		swc_pkg::CNT_W'(swc_pkg::STAB_CYCLES - 1);

	// pending is sampled at the instruction itself; later arrivals let it finish
	assign take_nop = (state == swc_pkg::ST_RUN) && sleep_instr && pending; // R2
	assign complete = (state == swc_pkg::ST_EXEC) && (cnt == EXEC_LAST);
	assign wake_now = (state == swc_pkg::ST_SLEEP) && pending;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		unique case (state)
			swc_pkg::ST_RUN: begin
				next_cnt = '0;
				if (sleep_instr && !pending) begin
					next_state = swc_pkg::ST_EXEC;
				end
			end
			swc_pkg::ST_EXEC: begin
				next_cnt = cnt + 1'b1;
				if (complete) begin
					next_cnt = '0;
					next_state = swc_pkg::ST_SLEEP; // R5
				end
			end
			swc_pkg::ST_SLEEP: begin
				next_cnt = '0;
				if (pending || wake_seen) begin
					// R11 R12
					next_state = lp_sleep ? swc_pkg::ST_STAB : swc_pkg::ST_RUN;
				end
			end
			swc_pkg::ST_STAB: begin
				next_cnt = cnt + 1'b1;
				if (cnt == STAB_LAST) begin
					next_cnt = '0;
					next_state = swc_pkg::ST_RUN; // R12
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= swc_pkg::ST_RUN;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// a source that fires mid-instruction may drop again; remember it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_seen <= 1'b0;
		end else if (state == swc_pkg::ST_EXEC) begin
			wake_seen <= wake_seen | pending; // R5
		end else if (state == swc_pkg::ST_SLEEP) begin
			wake_seen <= 1'b0;
		end
	end

	// mode is frozen at sleep entry so a late write cannot skip the delay
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lp_sleep <= 1'b0;
		end else if (complete) begin
			lp_sleep <= regulator_power_mode; // R10
		end
	end

	// ==========================================================
	// core and watchdog outputs
	logic resume_go;

	assign resume_go = ((state == swc_pkg::ST_SLEEP) && (pending || wake_seen) && !lp_sleep)
		|| ((state == swc_pkg::ST_STAB) && (cnt == STAB_LAST));

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			resume <= 1'b0;
			resume_vector <= 1'b0;
			sleep_nop <= 1'b0;
			wdt_clear <= 1'b0;
			wdt_prescaler_clear <= 1'b0;
		end else begin
			resume <= resume_go;
			resume_vector <= resume_go && global_irq_enable; // R13
			sleep_nop <= take_nop; // R2 R3
			wdt_clear <= complete; // R6 R3
			wdt_prescaler_clear <= complete; // R6 R3
		end
	end

	assign core_stall = (state != swc_pkg::ST_RUN);
	assign sleeping = (state == swc_pkg::ST_SLEEP);
	assign regulator_enable = 1'b1; // R9
	assign regulator_low_power = sleeping && lp_sleep; // R10 R11

	// ==========================================================
	// time-out and power-down flags
	logic flags_wr;

	assign flags_wr = reg_write && reg_addr == swc_pkg::REG_FLAGS;

	// firmware may only set the flags; hardware events win over its write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timeout_flag_n <= swc_pkg::TO_RST;
		end else if (wdt_timeout) begin
			timeout_flag_n <= 1'b0;
		end else if (complete) begin
			timeout_flag_n <= 1'b1; // R7 R4
		end else if (flags_wr && reg_wdata[swc_pkg::FLAG_TO_BIT]) begin
			timeout_flag_n <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			powerdown_flag_n <= swc_pkg::PD_RST;
		end else if (complete) begin
			powerdown_flag_n <= 1'b0; // R7 R4 R8
		end else if (flags_wr && reg_wdata[swc_pkg::FLAG_PD_BIT]) begin
			powerdown_flag_n <= 1'b1;
		end
	end

	// ==========================================================
	// event status, cleared by reading it
	logic [swc_pkg::NUM_EV-1:0] ev_status;
	logic [swc_pkg::NUM_EV-1:0] ev_set;
	logic ev_rd;

	assign ev_set = {resume_go, complete, take_nop};
	assign ev_rd = reg_read && reg_addr == swc_pkg::REG_EVENT;

	// a new event in the reading cycle survives the clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ev_status <= '0;
		end else begin
			ev_status <= (ev_rd ? '0 : ev_status) | ev_set;
		end
	end

	assign irq = |(ev_status & ev_mask);

	// ==========================================================
	// read port
	logic [swc_pkg::DATA_W-1:0] next_rdata;

	always_comb begin
		next_rdata = '0;
		unique case (reg_addr)
			swc_pkg::REG_CONTROL: next_rdata = control;
			swc_pkg::REG_FLAGS: next_rdata = {6'h00, powerdown_flag_n, timeout_flag_n};
			swc_pkg::REG_EVENT: next_rdata = {5'h00, ev_status};
			swc_pkg::REG_MASK: next_rdata = {5'h00, ev_mask};
			swc_pkg::REG_STATE: next_rdata = {4'h0, state};
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule

// [design/swc_wake_qual.sv]
// qualifies interrupt sources that may wake the device
`timescale 1ns/100ps
module swc_wake_qual #(
	parameter int unsigned N = 16,
	parameter int unsigned EXCL = 0
) (
	input wire logic [N-1:0] irq_enable,
	input wire logic [N-1:0] irq_flag,
	output logic pending
);
	logic [N-1:0] qual;

	always_comb begin
		qual = irq_enable & irq_flag;
		// the clock-switch source never wakes
		qual[EXCL] = 1'b0;
		pending = |qual;
	end
endmodule

// [include/swc_pkg.sv]
// constants for the sleep and wake-up controller
package swc_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SLEEP_EXEC_CYCLES = 2;
	localparam int unsigned STAB_TIME_NS = 1000;
	localparam int unsigned STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 8;

	// ==========================================================
	// interrupt sources
	localparam int unsigned NUM_SRC = 16;
	localparam int unsigned CLKSW_SRC = 0;

	// ==========================================================
	// register bus
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_FLAGS = 4'h1;
	localparam logic [3:0] REG_EVENT = 4'h2;
	localparam logic [3:0] REG_MASK = 4'h3;
	localparam logic [3:0] REG_STATE = 4'h4;

	// field positions
	localparam int unsigned CTRL_PM_BIT = 0;
	localparam int unsigned FLAG_TO_BIT = 0;
	localparam int unsigned FLAG_PD_BIT = 1;
	localparam int unsigned EV_NOP_BIT = 0;
	localparam int unsigned EV_SLEEP_BIT = 1;
	localparam int unsigned EV_WAKE_BIT = 2;
	localparam int unsigned NUM_EV = 3;

	// reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic TO_RST = 1'b1;
	localparam logic PD_RST = 1'b1;

	// ==========================================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_SLEEP = 4'b0100,
		ST_STAB = 4'b1000
	} swc_state_t;

endpackage

// [testbench/swc_core_model.sv]
// core model: issues sleep and raises one interrupt source
`timescale 1ns/100ps
module swc_core_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic go,
	input wire logic [7:0] dly,
	input wire logic [3:0] src,
	input wire logic clr,
	output logic sleep_instr,
	output logic [15:0] irq_flag
);
	logic [7:0] cnt;
	// zero delay: flag rises with the instruction, so it is already pending when taken
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sleep_instr <= 1'b0;
			irq_flag <= 16'h0000;
			cnt <= 8'h00;
		end else begin
			sleep_instr <= go;
			cnt <= (cnt > 8'h01) ? cnt - 8'h01 : 8'h00;
			if (go)
				cnt <= dly;
			if ((go && dly == 8'h00) || cnt == 8'h01)
				irq_flag[src] <= 1'b1;
			if (clr)
				irq_flag <= 16'h0000;
		end
	end
endmodule

// [testbench/swc_monitor.sv]
// assertion checker for the sleep controller ports
`timescale 1ns/100ps
module swc_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sleep_instr,
	input wire logic global_irq_enable,
	input wire logic [swc_pkg::NUM_SRC-1:0] irq_enable,
	input wire logic [swc_pkg::NUM_SRC-1:0] irq_flag,
	input wire logic core_stall,
	input wire logic sleeping,
	input wire logic resume,
	input wire logic resume_vector,
	input wire logic sleep_nop,
	input wire logic wdt_clear,
	input wire logic wdt_prescaler_clear,
	input wire logic regulator_enable,
	input wire logic regulator_low_power,
	input wire logic timeout_flag_n,
	input wire logic powerdown_flag_n
);
	// source 0 is the clock switch and never counts
	wire pend = |(irq_enable & irq_flag & 16'hfffe);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_take;
		sleep_instr && !core_stall;
	endsequence
	sequence s_stab;
		!resume [*8] ##93 resume;
	endsequence
	property p_nop;
		s_take ##0 pend |=> sleep_nop && !wdt_clear;
	endproperty
	a_nop: assert property (p_nop) else $error("pending sleep not a no-op");
	property p_clksw;
		s_take ##0 !pend |=> !sleep_nop;
	endproperty
	a_clksw: assert property (p_clksw) else $error("no-op without qualified source");
	property p_keep;
		sleep_nop |-> !wdt_prescaler_clear;
	endproperty
	a_keep: assert property (p_keep) else $error("watchdog cleared on no-op");
	property p_stat;
		sleep_nop |-> $stable(timeout_flag_n) && $stable(powerdown_flag_n);
	endproperty
	a_stat: assert property (p_stat) else $error("status changed on no-op");
	property p_done;
		s_take ##0 !pend |-> ##3 wdt_clear && wdt_prescaler_clear;
	endproperty
	a_done: assert property (p_done) else $error("watchdog not cleared on sleep");
	property p_flag;
		wdt_clear |-> timeout_flag_n && !powerdown_flag_n;
	endproperty
	a_flag: assert property (p_flag) else $error("status wrong after sleep");
	property p_reg;
		regulator_enable;
	endproperty
	a_reg: assert property (p_reg) else $error("regulator off");
	property p_lp;
		regulator_low_power |-> sleeping;
	endproperty
	a_lp: assert property (p_lp) else $error("low power while awake");
	property p_fast;
		sleeping && pend && !regulator_low_power |=> resume && !sleeping;
	endproperty
	a_fast: assert property (p_fast) else $error("normal wake delayed");
	property p_slow;
		sleeping && pend && regulator_low_power |=> s_stab;
	endproperty
	a_slow: assert property (p_slow) else $error("low power wake timing");
	property p_vec;
		resume |-> resume_vector == $past(global_irq_enable);
	endproperty
	a_vec: assert property (p_vec) else $error("vector with interrupts off");
	property p_stall;
		s_take ##0 !pend |=> core_stall [*3];
	endproperty
	a_stall: assert property (p_stall) else $error("core not held during sleep");
	property p_run;
		resume |-> !core_stall && !sleeping;
	endproperty
	a_run: assert property (p_run) else $error("core still held at resume");
endmodule

// [testbench/tb.sv]
// self-checking bench for the sleep controller
`timescale 1ns/100ps
module tb;
	logic core_clk = 1'b0, rst = 1'b1, go = 1'b0, clr = 1'b0, global_irq_enable = 1'b0;
	logic wdt_timeout = 1'b0, reg_write = 1'b0, reg_read = 1'b0, sleep_instr;
	logic [7:0] dly = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [3:0] src = 4'h1, reg_addr = 4'h0;
	logic [15:0] irq_enable = 16'hffff, irq_flag;
	logic core_stall, sleeping, resume, resume_vector, sleep_nop, wdt_clear, irq;
	logic wdt_prescaler_clear, regulator_enable, regulator_low_power;
	logic timeout_flag_n, powerdown_flag_n;
	logic [31:0] m;
	int err_total = 0, checks = 0, seed = 32'h8ea40afc, n;
	always #5 core_clk = ~core_clk;
	swc_core_model u_swc_core_model (.core_clk, .rst, .go, .dly, .src, .clr, .sleep_instr,
		.irq_flag);
	swc_sleep_ctrl u_swc_sleep_ctrl (.core_clk, .rst, .sleep_instr, .global_irq_enable,
		.irq_enable, .irq_flag, .wdt_timeout, .core_stall, .sleeping, .resume, .resume_vector,
		.sleep_nop, .wdt_clear, .wdt_prescaler_clear, .regulator_enable, .regulator_low_power,
		.timeout_flag_n, .powerdown_flag_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .irq);
	// ==========================================================
	// checking and bus tasks
	task conclude;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
		// idle edge so a following write never re-raises the strobe in this step
		@(posedge core_clk);
	endtask
	task rdchk(input string nm, input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		@(negedge core_clk);
		chk(nm, reg_rdata, e);
		@(posedge core_clk);
	endtask
	// waits for the no-op or the resume pulse, n counts whole cycles from the request
	task sleep(input logic [7:0] d, input logic [3:0] s);
		src <= s;
		dly <= d;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		for (n = 0; n < 400 && resume !== 1'b1 && sleep_nop !== 1'b1; n++)
			@(negedge core_clk);
		@(posedge core_clk);
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
	endtask
	function automatic logic [7:0] exp_ev(input logic pre);
		return pre ? 8'h01 : 8'h06;
	endfunction
	function automatic logic [7:0] exp_flags(input logic pre);
		return pre ? 8'h03 : 8'h01;
	endfunction
	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rdchk("flags", swc_pkg::REG_FLAGS, 8'h03);
		rdchk("control", swc_pkg::REG_CONTROL, 8'h00);
		rdchk("unmapped", 4'hf, 8'h00);
		for (int i = 0; i < 14; i++) begin
			m = $random(seed);
			irq_enable <= m[31:16] | 16'h0001;
			global_irq_enable <= m[1];
			wr(swc_pkg::REG_CONTROL, {7'h00, m[0]});
			wr(swc_pkg::REG_MASK, {5'h00, m[14:12]});
			rdchk("mask", swc_pkg::REG_MASK, {5'h00, m[14:12]});
			wr(swc_pkg::REG_FLAGS, 8'h03);
			irq_enable <= irq_enable | (16'h0001 << (1 + m[11:8] % 15));
			sleep(m[2] ? 8'h00 : {5'h00, m[6:4]} + 8'h01, 4'(1 + m[11:8] % 15));
			chk("wait", n < 400, 1'b1);
			chk("slow", n > swc_pkg::STAB_CYCLES, m[0] && !m[2]);
			chk("irq", irq, |(exp_ev(m[2]) & {5'h00, m[14:12]}));
			rdchk("flags", swc_pkg::REG_FLAGS, exp_flags(m[2]));
			rdchk("events", swc_pkg::REG_EVENT, exp_ev(m[2]));
			chk("irq clr", irq, 1'b0);
		end
		wr(swc_pkg::REG_CONTROL, 8'h00);
		// every source enabled, the clock switch included, so only its exclusion keeps us asleep
		irq_enable <= 16'hffff;
		go <= 1'b1;
		src <= 4'h0;
		dly <= 8'h00;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (8) @(negedge core_clk);
		chk("clock switch", sleeping, 1'b1);
		@(posedge core_clk);
		rdchk("state", swc_pkg::REG_STATE, 8'h04);
		sleep(8'h02, 4'h3);
		chk("wake", n < 400, 1'b1);
		wdt_timeout <= 1'b1;
		@(posedge core_clk);
		wdt_timeout <= 1'b0;
		wr(swc_pkg::REG_FLAGS, 8'h02);
		rdchk("timeout", swc_pkg::REG_FLAGS, 8'h02);
		conclude();
	end
	initial begin
		#100us;
		err_total++;
		conclude();
	end
endmodule
bind swc_sleep_ctrl swc_monitor u_swc_monitor (.core_clk, .rst, .sleep_instr,
	.global_irq_enable, .irq_enable, .irq_flag, .core_stall, .sleeping, .resume,
	.resume_vector, .sleep_nop, .wdt_clear, .wdt_prescaler_clear, .regulator_enable,
	.regulator_low_power, .timeout_flag_n, .powerdown_flag_n);
